// ==== common/frs_pkg.sv ====
// Constants and carrier types for the flash row erase/write sequencer
package frs_pkg;
	// ----------------------------------------
	// Geometry and timing
	// ----------------------------------------
	localparam int LATCH_COUNT = 32;
	localparam int WORD_W = 14;
	localparam int IDX_W = 5;
	localparam int ROW_W = 10;
	localparam int CLK_MHZ = 20;
	localparam int OP_TIME_US = 2000;
	localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
	localparam int CNT_W = 16;
	localparam logic [WORD_W-1:0] BLANK_WORD = 14'h3FFF;

	// ----------------------------------------
	// Unlock key values
	// ----------------------------------------
	localparam logic [7:0] UNLOCK_KEY_1 = 8'h55;
	localparam logic [7:0] UNLOCK_KEY_2 = 8'hAA;

	// ----------------------------------------
	// Control register bit positions
	// ----------------------------------------
	localparam int CTRL_RD = 0;
	localparam int CTRL_WR = 1;
	localparam int CTRL_WRITE_ENABLE_BIT = 2;
	localparam int CTRL_PROGRAM_ERROR_FLAG = 3;
	localparam int CTRL_FREE = 4;
	localparam int CTRL_LATCH_ONLY_SELECT = 5;
	localparam int CTRL_CFG_SPACE_SELECT = 6;
	localparam int CTRL_TOP = 7;
	localparam int ADDR_HI_W = 7;
	localparam int DAT_HI_W = 6;

	// Register selector on the core's special register port
	typedef enum logic [2:0] {
		SEL_ADDR_LOW = 3'h0,
		SEL_ADDR_HIGH = 3'h1,
		SEL_WDATA_LOW = 3'h2,
		SEL_WDATA_HIGH = 3'h3,
		SEL_CTRL = 3'h4,
		SEL_UNLOCK = 3'h5
	} frs_sel_type;

	// One access from the core
	typedef struct packed {
		logic wr;
		logic rd;
		frs_sel_type sel;
		logic [7:0] data;
	} frs_req_type;

	typedef enum logic [1:0] {UL_IDLE, UL_GOT_FIRST, UL_ARMED} frs_unlock_type;
	typedef enum logic [1:0] {PH_IDLE, PH_NOP1, PH_NOP2, PH_BUSY} frs_phase_type;
endpackage

// ==== rtl/frs_sequencer.sv ====
// Flash row erase/write sequencer with unlock, write latches and core stall
module frs_sequencer
	import frs_pkg::*;
#(
	parameter int OP_CYC = OP_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic power_on,
	input wire frs_pkg::frs_req_type sfr_req,
	output logic [7:0] sfr_rdata,
	output logic force_nop,
	output logic cpu_stall,
	output logic flash_busy,
	output logic flash_erase_go,
	output logic flash_prog_go,
	output logic [frs_pkg::ROW_W-1:0] flash_row,
	output logic [frs_pkg::LATCH_COUNT*frs_pkg::WORD_W-1:0] flash_row_words
);
	import frs_pkg::*;

	typedef struct packed {
		logic [ADDR_HI_W-1:0] addr_hi;
		logic [7:0] addr_lo;
		logic [7:0] dat_lo;
		logic [DAT_HI_W-1:0] dat_hi;
		logic cfg_space_select;
		logic latch_only_select;
		logic free;
		logic program_error_flag;
		logic write_enable_bit;
		logic wr;
		logic erase_op;
		frs_unlock_type unlock;
		frs_phase_type phase;
		logic [CNT_W-1:0] cnt;
		logic [LATCH_COUNT-1:0][WORD_W-1:0] latch;
		logic [7:0] rdata;
		logic rst_seen;
		logic erase_go;
		logic prog_go;
	} frs_state_type;

	frs_state_type s_q;
	frs_state_type s_d;
	logic op_shadow_q;
	logic ctrl_wr;
	logic trig_try;
	logic trig_ok;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Control register image as the core sees it
	function automatic logic [7:0] ctrl_image(input frs_state_type s);
		logic [7:0] v;
		v = 8'h00;
		v[CTRL_TOP] = 1'b1;
		v[CTRL_CFG_SPACE_SELECT] = s.cfg_space_select;
		v[CTRL_LATCH_ONLY_SELECT] = s.latch_only_select;
		v[CTRL_FREE] = s.free;
		v[CTRL_PROGRAM_ERROR_FLAG] = s.program_error_flag;
		v[CTRL_WRITE_ENABLE_BIT] = s.write_enable_bit;
		v[CTRL_WR] = s.wr;
		return v;
	endfunction

	localparam logic [CNT_W-1:0] OP_LAST = CNT_W'(OP_CYC - 1);

	assign ctrl_wr = sfr_req.wr && (sfr_req.sel == SEL_CTRL);
	assign trig_try = ctrl_wr && sfr_req.data[CTRL_WR] && (s_q.phase == PH_IDLE);
	assign trig_ok = trig_try && (s_q.unlock == UL_ARMED) && sfr_req.data[CTRL_WRITE_ENABLE_BIT]
		&& !sfr_req.data[CTRL_CFG_SPACE_SELECT];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.erase_go = 1'b0;
		s_d.prog_go = 1'b0;
		s_d.rst_seen = 1'b1;

		// Register reads
		if (sfr_req.rd) begin
			unique case (sfr_req.sel)
				SEL_ADDR_LOW: s_d.rdata = s_q.addr_lo;
				SEL_ADDR_HIGH: s_d.rdata = {1'b1, s_q.addr_hi};
				SEL_WDATA_LOW: s_d.rdata = s_q.dat_lo;
				SEL_WDATA_HIGH: s_d.rdata = {2'b00, s_q.dat_hi};
				SEL_CTRL: s_d.rdata = ctrl_image(s_q);
				SEL_UNLOCK: s_d.rdata = 8'h00;
				default: s_d.rdata = 8'h00;
			endcase
		end

		// Register writes
		if (sfr_req.wr) begin
			unique case (sfr_req.sel)
				SEL_ADDR_LOW: s_d.addr_lo = sfr_req.data;
				SEL_ADDR_HIGH: s_d.addr_hi = sfr_req.data[ADDR_HI_W-1:0];
				SEL_WDATA_LOW: s_d.dat_lo = sfr_req.data;
				SEL_WDATA_HIGH: s_d.dat_hi = sfr_req.data[DAT_HI_W-1:0];
				SEL_CTRL: begin
					s_d.cfg_space_select = sfr_req.data[CTRL_CFG_SPACE_SELECT];
					s_d.latch_only_select = sfr_req.data[CTRL_LATCH_ONLY_SELECT];
					s_d.free = sfr_req.data[CTRL_FREE];
					s_d.write_enable_bit = sfr_req.data[CTRL_WRITE_ENABLE_BIT];
					s_d.program_error_flag = sfr_req.data[CTRL_PROGRAM_ERROR_FLAG]; // Software may clear it
				end
				SEL_UNLOCK: ;
				default: ;
			endcase
		end

		// Catch an operation cut by reset, wins over a write
		if (!s_q.rst_seen && op_shadow_q) begin
			s_d.program_error_flag = 1'b1;
		end

		// Unlock tracker, any other access drops it
		if (sfr_req.wr || sfr_req.rd) begin
			s_d.unlock = UL_IDLE;
			if (sfr_req.wr && sfr_req.sel == SEL_UNLOCK) begin
				if (sfr_req.data == UNLOCK_KEY_1) begin
					s_d.unlock = UL_GOT_FIRST;
				end else if (sfr_req.data == UNLOCK_KEY_2 && s_q.unlock == UL_GOT_FIRST) begin
					s_d.unlock = UL_ARMED;
				end
			end
		end

		// Rejected trigger flags an error, starts nothing
		if (trig_try && !trig_ok) begin
			s_d.program_error_flag = 1'b1;
		end

		if (trig_ok) begin
			s_d.wr = 1'b1;
			s_d.erase_op = sfr_req.data[CTRL_FREE];
			// Two setup cycles follow the trigger
			s_d.phase = PH_NOP1;
			// Low five address bits pick the latch
			if (!sfr_req.data[CTRL_FREE]) begin
				// Latch load on every write trigger
				s_d.latch[s_q.addr_lo[IDX_W-1:0]] = {s_q.dat_hi, s_q.dat_lo};
			end
		end

		// Sequencing after a trigger
		unique case (s_q.phase)
			PH_IDLE: ;
			PH_NOP1: s_d.phase = PH_NOP2;
			PH_NOP2: begin
				if (s_q.latch_only_select && !s_q.erase_op) begin
					// Latch load ends here with no stall
					s_d.phase = PH_IDLE;
					s_d.wr = 1'b0;
				end else begin
					// Program whole row; or erase it
					s_d.phase = PH_BUSY;
					s_d.cnt = '0;
					s_d.erase_go = s_q.erase_op;
					s_d.prog_go = !s_q.erase_op;
				end
			end
			PH_BUSY: begin
				if (s_q.cnt == OP_LAST) begin
					// Release the core; hardware clears trigger
					s_d.phase = PH_IDLE;
					s_d.wr = 1'b0;
					s_d.free = 1'b0;
					for (int i = 0; i < LATCH_COUNT; i++) begin
						s_d.latch[i] = BLANK_WORD;
					end
				end else begin
					s_d.cnt = s_q.cnt + 1'b1;
				end
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Enable and all control bits clear at reset
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.unlock <= UL_IDLE;
			s_q.phase <= PH_IDLE;
			s_q.latch <= {LATCH_COUNT{BLANK_WORD}};
		end else begin
			s_q <= s_d;
		end
	end

	// Operation-in-flight shadow, held through reset and cleared at power-on; out of reset it follows the phase except during a latch-only load
	always_ff @(posedge sys_clk) begin
		if (power_on) begin
			op_shadow_q <= 1'b0;
		end else if (rst_b) begin
			op_shadow_q <= (s_q.phase != PH_IDLE) && !(s_q.latch_only_select && !s_q.erase_op);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// No-op forcing; stall while self-timed
	assign force_nop = (s_q.phase == PH_NOP1) || (s_q.phase == PH_NOP2);
	assign cpu_stall = (s_q.phase == PH_BUSY);
	assign flash_busy = (s_q.phase == PH_BUSY);
	assign sfr_rdata = s_q.rdata;
	assign flash_erase_go = s_q.erase_go;
	assign flash_prog_go = s_q.prog_go;
	// Row erase ignores the low latch bits
	assign flash_row = {s_q.addr_hi, s_q.addr_lo[7:IDX_W]};
	// Row image, one latch per word; no erase implied
	assign flash_row_words = s_q.latch;
endmodule

// ==== tb/frs_core_model.sv ====
// Core model issuing register accesses
module frs_core_model
	import frs_pkg::*;
(
	input wire logic sys_clk,
	output frs_pkg::frs_req_type sfr_req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial sfr_req = '0;
	// One access, taken at the next edge
	task automatic acc(input logic w, input frs_sel_type s, input logic [7:0] d);
		sfr_req = '{w, !w, s, d};
		@(posedge sys_clk);
		sfr_req <= '0;
		#1;
	endtask
	task automatic fire(input logic [7:0] c);
		acc(1'b1, SEL_UNLOCK, UNLOCK_KEY_1);
		acc(1'b1, SEL_UNLOCK, UNLOCK_KEY_2);
		acc(1'b1, SEL_CTRL, c);
	endtask
endmodule

// ==== tb/frs_props.sv ====
// Port timing checker for the sequencer
module frs_props
	import frs_pkg::*;
#(
	parameter int OP_CYC = 8
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic power_on,
	input wire frs_pkg::frs_req_type sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic force_nop,
	input wire logic cpu_stall,
	input wire logic flash_busy,
	input wire logic flash_erase_go,
	input wire logic flash_prog_go,
	input wire logic [frs_pkg::ROW_W-1:0] flash_row,
	input wire logic [frs_pkg::LATCH_COUNT*frs_pkg::WORD_W-1:0] flash_row_words
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic [15:0] cnt_q;
	// Stall length counter
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cpu_stall ? cnt_q + 16'h1 : 16'h0;
		end
	end
	logic [1:0] ul_q;
	// Reference unlock tracker, any access but the key pair drops it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ul_q <= 2'h0;
		end else if (sfr_req.wr || sfr_req.rd) begin
			if (sfr_req.wr && sfr_req.sel == SEL_UNLOCK && sfr_req.data == UNLOCK_KEY_1) begin
				ul_q <= 2'h1;
			end else if (sfr_req.wr && sfr_req.sel == SEL_UNLOCK
				&& sfr_req.data == UNLOCK_KEY_2 && ul_q == 2'h1) begin
				ul_q <= 2'h2;
			end else begin
				ul_q <= 2'h0;
			end
		end
	end
	a_nop_two: assert property ($rose(force_nop) |=> force_nop ##1 !force_nop)
		else $error("forced idle not two cycles");
	a_stall_len: assert property ($fell(cpu_stall) |-> cnt_q == 16'(OP_CYC))
		else $error("stall length wrong");
	a_stall_after: assert property ($rose(cpu_stall) |-> $past(force_nop, 2) && !force_nop)
		else $error("stall not after idle cycles");
	a_busy_stall: assert property (flash_busy == cpu_stall)
		else $error("busy differs from stall");
	a_go_start: assert property (flash_erase_go || flash_prog_go |-> $rose(cpu_stall))
		else $error("go pulse off stall start");
	a_blank_end: assert property ($fell(cpu_stall) |-> flash_row_words == {32{BLANK_WORD}})
		else $error("latches not blank after op");
	a_unlock_zero: assert property (sfr_req.rd && sfr_req.sel == SEL_UNLOCK |=> !sfr_rdata)
		else $error("unlock read not zero");
	a_no_unlock: assert property (sfr_req.wr && sfr_req.sel == SEL_CTRL && sfr_req.data[CTRL_WR]
		&& !force_nop && !cpu_stall && !(ul_q == 2'h2 && sfr_req.data[CTRL_WRITE_ENABLE_BIT]
		&& !sfr_req.data[CTRL_CFG_SPACE_SELECT]) |=> !force_nop)
		else $error("trigger without unlock accepted");
	cover property ($rose(flash_erase_go));
	cover property ($rose(flash_prog_go));
	cover property ($rose(force_nop) ##3 !cpu_stall);
endmodule
bind frs_sequencer frs_props #(.OP_CYC(OP_CYC)) u_props (.sys_clk, .rst_b, .power_on,
	.sfr_req, .sfr_rdata, .force_nop, .cpu_stall, .flash_busy, .flash_erase_go,
	.flash_prog_go, .flash_row, .flash_row_words);

// ==== tb/tb_frs_sequencer.sv ====
// Self-checking bench for the flash sequencer
module tb_frs_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	import frs_pkg::*;
	localparam int SIM_OP_CYC = 8;
	logic sys_clk;
	logic rst_b;
	logic power_on;
	frs_req_type sfr_req;
	logic [7:0] sfr_rdata;
	logic force_nop, cpu_stall, flash_busy, flash_erase_go, flash_prog_go;
	logic [9:0] flash_row;
	logic [447:0] flash_row_words;
	logic [447:0] bl = {32{BLANK_WORD}};
	logic [18:0] rows [5] = '{19'h0A5A5, 19'h1FFFF, 19'h23C3C, 19'h3FF3F, 19'h55500};
	int errors = 0;
	int samples_checked = 0;
	initial sys_clk = 1'b0;
	always #25 sys_clk = ~sys_clk;
	frs_core_model core_u (.sys_clk(sys_clk), .sfr_req(sfr_req));
	frs_sequencer #(.OP_CYC(SIM_OP_CYC)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
		.power_on(power_on), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .force_nop(force_nop),
		.cpu_stall(cpu_stall), .flash_busy(flash_busy), .flash_erase_go(flash_erase_go),
		.flash_prog_go(flash_prog_go), .flash_row(flash_row), .flash_row_words(flash_row_words));
	task automatic chk(input string n, input logic [447:0] e, g);
		samples_checked++;
		if (e !== g) begin
			errors++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input frs_sel_type s, input logic [7:0] e);
		core_u.acc(1'b0, s, 8'h00);
		chk("rdata", e, sfr_rdata);
	endtask
	// Records idle, stall and go pulses after a trigger
	task automatic watch(input logic [11:0] en, es, eg, ep, input logic [447:0] ew, ee);
		logic [11:0] n, s, g, p;
		logic [447:0] w;
		for (int i = 0; i < 12; i++) begin
			n[i] = force_nop;
			s[i] = cpu_stall;
			g[i] = flash_erase_go;
			p[i] = flash_prog_go;
			if (i == 2) w = flash_row_words;
			step(1);
		end
		chk("nop", en, n);
		chk("stall", es, s);
		chk("erase_go", eg, g);
		chk("prog_go", ep, p);
		chk("mid_words", ew, w);
		chk("end_words", ee, flash_row_words);
	endtask
	task automatic finish_test();
		if (errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		rst_b = 1'b0;
		power_on = 1'b1;
		step(20);
		rst_b = 1;
		power_on = 0;
		chk("words", bl, flash_row_words);
		rd(SEL_CTRL, 8'h80);
		for (int i = 0; i < 5; i++) begin
			core_u.acc(1'b1, frs_sel_type'(rows[i][18:16]), rows[i][15:8]);
			rd(frs_sel_type'(rows[i][18:16]), rows[i][7:0]);
		end
		core_u.fire(8'h02);
		watch(12'h0, 12'h0, 12'h0, 12'h0, bl, bl);
		rd(SEL_CTRL, 8'h88);
		core_u.acc(1'b1, SEL_ADDR_HIGH, 8'h7F);
		core_u.acc(1'b1, SEL_ADDR_LOW, 8'hFF);
		core_u.acc(1'b1, SEL_WDATA_HIGH, 8'h2A);
		core_u.acc(1'b1, SEL_WDATA_LOW, 8'hBC);
		core_u.acc(1'b1, SEL_CTRL, 8'h24);
		core_u.fire(8'h26);
		watch(12'h3, 12'h0, 12'h0, 12'h0, {14'h2ABC, bl[433:0]},
			{14'h2ABC, bl[433:0]});
		chk("row", 10'h3FF, flash_row);
		core_u.acc(1'b1, SEL_UNLOCK, 8'h55);
		rd(SEL_ADDR_LOW, 8'hFF);
		core_u.acc(1'b1, SEL_UNLOCK, 8'hAA);
		core_u.acc(1'b1, SEL_CTRL, 8'h26);
		watch(12'h0, 12'h0, 12'h0, 12'h0, {14'h2ABC, bl[433:0]},
			{14'h2ABC, bl[433:0]});
		core_u.fire(8'h46);
		watch(12'h0, 12'h0, 12'h0, 12'h0, {14'h2ABC, bl[433:0]},
			{14'h2ABC, bl[433:0]});
		core_u.acc(1'b1, SEL_WDATA_LOW, 8'h11);
		core_u.acc(1'b1, SEL_CTRL, 8'h04);
		core_u.fire(8'h06);
		watch(12'h3, 12'h3FC, 12'h0, 12'h4, {14'h2A11, bl[433:0]}, bl);
		core_u.acc(1'b0, SEL_CTRL, 8'h00);
		chk("ctrl", 8'h84, sfr_rdata);
		core_u.acc(1'b1, SEL_ADDR_HIGH, 8'h03);
		core_u.acc(1'b1, SEL_ADDR_LOW, 8'h25);
		core_u.acc(1'b1, SEL_CTRL, 8'h14);
		core_u.fire(8'h16);
		watch(12'h3, 12'h3FC, 12'h4, 12'h0, bl, bl);
		chk("row", 10'h019, flash_row);
		core_u.acc(1'b1, SEL_CTRL, 8'h04);
		core_u.fire(8'h06);
		step(4);
		rst_b = 0;
		step(2);
		chk("stall", 1'b0, cpu_stall);
		rst_b = 1;
		step(2);
		rd(SEL_CTRL, 8'h88);
		finish_test();
	end
	// Hang guard
	initial begin
		repeat (3000) @(posedge sys_clk);
		errors++;
		finish_test();
	end
endmodule
